// ===== design/edge_cycle_counter_sleep_timer.v
// Behaviour
// - software reads the full 8-bit counter at any time without upset.
// - software writes an 8-bit value that the counter continues from.
// - internal source unprescaled advances once every four clocks.
// - prescaled internal sources advance every 64 or 1024 clocks.
// - internal counting stops while the sleep state is active.
// - external rising mode counts each low-to-high pin transition.
// - external falling mode counts each high-to-low pin transition.
// - gated count zeroes the counter, counts for n ms, returns the count.
// - rollover wait stalls until the counter wraps to zero.
// - sleep suspends for n periods of nominally 18 ms each.
// - a sleep alters the edge and source settings of the counter.
// - the watchdog resets the processor when not restarted in time.
// - the watchdog is not a user resource; only sleep and recovery use it. Here sleep times its periods with tick_r, not the watchdog.
// - delay blocks for a 16-bit number of milliseconds.
//
// Purpose: 8-bit event/cycle counter with sleep, delay and watchdog timing
// Assumes: APB slave, 25 MHz sys_clk, synchronous active-high rst
// Notes: busy operations stretch pready so the master stalls meanwhile
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "edge_cycle_counter_defs.vh"
module edge_cycle_counter_sleep_timer #(
  parameter MS_CYCLES = `CYC_PER_MS,
  parameter SLEEP_CYCLES = `SLEEP_MS * `CYC_PER_MS,
  parameter WDT_CYCLES = `WDT_MS * `CYC_PER_MS
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire countPin,
  output reg sleeping,
  output reg wdtReset
);
  localparam ST_IDLE = 3'd0;
  localparam ST_GATE = 3'd1;
  localparam ST_DELAY = 3'd2;
  localparam ST_SLEEP = 3'd3;
  localparam ST_WAIT = 3'd4;
  localparam ST_DONE = 3'd5;

  reg [7:0] count_r;
  reg [3:0] ctrl_r;
  reg [2:0] state_r;
  reg [15:0] msLeft_r;
  reg [7:0] slpLeft_r;
  reg [31:0] tick_r;
  reg [9:0] pre_r;
  reg [31:0] wdt_r;
  reg wdtFired_r;
  reg [7:0] result_r;

  wire riseEvt;
  wire fallEvt;

  edge_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(countPin),
    .riseEvt(riseEvt),
    .fallEvt(fallEvt)
  );

  wire access = psel & penable;
  // only the first access edge acts; the pready edge must not repeat it
  wire firstAcc = access & ~pready;
  wire wrAcc = firstAcc & pwrite;
  wire idle = (state_r == ST_IDLE);
  wire [1:0] src = ctrl_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB];

  // address decode, one select per word
  wire selCount = (paddr == `OFS_COUNT);
  wire selCtrl = (paddr == `OFS_CTRL);
  wire selStatus = (paddr == `OFS_STATUS);
  wire selGate = (paddr == `OFS_GATE);
  wire selDelay = (paddr == `OFS_DELAY);
  wire selSleep = (paddr == `OFS_SLEEP);
  wire selKick = (paddr == `OFS_KICK);
  wire mapped = selCount | selCtrl | selStatus | selGate | selDelay |
    selSleep | selKick;

  // free-running prescaler, frozen in sleep so internal ticks stop there
  always @(posedge sys_clk) begin
    if (rst) begin
      pre_r <= 10'h000;
    end else if (state_r != ST_SLEEP) begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // prescaler runs only when awake; sleep stops the internal clock
  reg intTick;
  always @* begin
    case (src)
      `SRC_INT: intTick = (pre_r[1:0] == 2'h3);
      `SRC_INT16: intTick = (pre_r[5:0] == 6'h3f);
      `SRC_INT256: intTick = (pre_r == 10'h3ff);
      default: intTick = 1'b0;
    endcase
  end

  reg extTick;
  always @* begin
    if (src != `SRC_EXT)
      extTick = 1'b0;
    else if (ctrl_r[`CTRL_EDGE_BIT])
      extTick = fallEvt;
    else
      extTick = riseEvt;
  end

  wire countTick = (state_r != ST_SLEEP) & (intTick | extTick);
  wire [7:0] countNext = count_r + 8'h01;

  // operation requests, taken on the first access edge only
  wire countLoad = wrAcc & selCount & idle;
  wire ctrlWr = wrAcc & selCtrl & idle;
  wire startGate = wrAcc & selGate & idle;
  wire startDelay = wrAcc & selDelay & idle;
  wire startSleep = wrAcc & selSleep & idle;
  wire startWait = ctrlWr & pwdata[`CTRL_WAIT_BIT];
  wire msRun = (state_r == ST_GATE) | (state_r == ST_DELAY);
  wire msDone = (tick_r == MS_CYCLES - 1);
  wire slpDone = (tick_r == SLEEP_CYCLES - 1);
  wire lastMs = msDone & (msLeft_r == 16'h0001);
  wire lastSlp = slpDone & (slpLeft_r == 8'h01);

  // counter: a load or a gate start wins over a tick in the same cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      count_r <= 8'h00;
    end else if (countLoad) begin
      count_r <= pwdata[7:0];
    end else if (startGate) begin
      count_r <= 8'h00;
    end else if (countTick) begin
      count_r <= countNext;
    end
  end

  // control: bit 2 only starts a wait and is never stored
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (startSleep) begin
      ctrl_r <= `CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_r <= {pwdata[`CTRL_EDGE_BIT], 1'b0,
        pwdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB]};
    end
  end

  // operation engine; one at a time, the master is held meanwhile
  always @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startGate) begin
            if (pwdata[15:0] == 16'h0000) begin
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_GATE;
            end
          end else if (startDelay) begin
            if (pwdata[15:0] == 16'h0000) begin
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_DELAY;
            end
          end else if (startSleep) begin
            if (pwdata[7:0] == 8'h00) begin
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_SLEEP;
            end
          end else if (startWait) begin
            state_r <= ST_WAIT;
          end
        end
        ST_GATE: begin
          if (lastMs)
            state_r <= ST_DONE;
        end
        ST_DELAY: begin
          if (lastMs)
            state_r <= ST_DONE;
        end
        ST_SLEEP: begin
          if (lastSlp)
            state_r <= ST_DONE;
        end
        ST_WAIT: begin
          if (countTick && countNext == 8'h00)
            state_r <= ST_DONE;
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // one timebase serves ms steps and sleep periods; idle keeps it at zero
  always @(posedge sys_clk) begin
    if (rst) begin
      tick_r <= 32'h0;
    end else if (msRun) begin
      if (msDone) begin
        tick_r <= 32'h0;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end else if (state_r == ST_SLEEP) begin
      if (slpDone) begin
        tick_r <= 32'h0;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end else begin
      tick_r <= 32'h0;
    end
  end

  // millisecond budget of gate and delay, 16 bits wide
  always @(posedge sys_clk) begin
    if (rst) begin
      msLeft_r <= 16'h0000;
    end else if (startGate || startDelay) begin
      msLeft_r <= pwdata[15:0];
    end else if (msRun && msDone) begin
      msLeft_r <= msLeft_r - 16'h0001;
    end
  end

  // sleep periods left; stands at zero once the sleep is over
  always @(posedge sys_clk) begin
    if (rst) begin
      slpLeft_r <= 8'h00;
    end else if (startSleep) begin
      slpLeft_r <= pwdata[7:0];
    end else if (state_r == ST_SLEEP && slpDone) begin
      slpLeft_r <= slpLeft_r - 8'h01;
    end
  end

  // gate result: the count as it stands after the window's last edge
  always @(posedge sys_clk) begin
    if (rst) begin
      result_r <= 8'h00;
    end else if (state_r == ST_GATE && lastMs) begin
      result_r <= countTick ? countNext : count_r;
    end
  end

  // watchdog: private, restarted by any bus access or a kick write;
  // an operation in progress counts as alive since it ends by itself
  wire wdtKick = access | (state_r != ST_IDLE);
  always @(posedge sys_clk) begin
    if (rst) begin
      wdt_r <= 32'h0;
      wdtFired_r <= 1'b0;
      wdtReset <= 1'b0;
    end else begin
      wdtReset <= 1'b0;
      if (wdtKick) begin
        wdt_r <= 32'h0;
      end else if (wdt_r == WDT_CYCLES - 1) begin
        wdt_r <= 32'h0;
        wdtReset <= 1'b1;
        wdtFired_r <= 1'b1;
      end else begin
        wdt_r <= wdt_r + 32'h1;
      end
    end
  end

  wire busyFlag = ~idle;
  wire sleepFlag = (state_r == ST_SLEEP);
  wire waitFlag = (state_r == ST_WAIT);
  wire [3:0] statusBits = {wdtFired_r, waitFlag, sleepFlag, busyFlag};

  // read mux; the kick word and unmapped words read zero
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0;
    case (paddr)
      `OFS_COUNT: begin
        rdMux = {24'h0, count_r};
      end
      `OFS_CTRL: begin
        rdMux = {28'h0, ctrl_r};
      end
      `OFS_STATUS: begin
        rdMux = {28'h0, statusBits};
      end
      `OFS_GATE: begin
        rdMux = {24'h0, result_r};
      end
      `OFS_DELAY: begin
        rdMux = {16'h0, msLeft_r};
      end
      `OFS_SLEEP: begin
        rdMux = {24'h0, slpLeft_r};
      end
      default: rdMux = 32'h0;
    endcase
  end

  // plain words answer at once, operation writes only at done
  wire opWrite = pwrite & (selGate | selDelay | selSleep |
    (selCtrl & pwdata[`CTRL_WAIT_BIT]));
  wire plainAns = firstAcc & ~opWrite & idle;
  wire opAns = firstAcc & opWrite & (state_r == ST_DONE);

  // bus answer, straight from flip-flops
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= plainAns | opAns;
      pslverr <= plainAns & ~mapped;
      if (plainAns) begin
        prdata <= rdMux;
      end else if (opAns) begin
        prdata <= {24'h0, result_r};
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= sleepFlag;
    end
  end
endmodule

// ===== design/edge_cycle_counter_defs.vh
// Purpose: constants for the event cycle counter and sleep timer block
// Assumes: 25 MHz system clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
`ifndef EDGE_CYCLE_COUNTER_DEFS_VH
`define EDGE_CYCLE_COUNTER_DEFS_VH

`define OFS_COUNT 12'h000
`define OFS_CTRL 12'h004
`define OFS_STATUS 12'h008
`define OFS_GATE 12'h00c
`define OFS_DELAY 12'h010
`define OFS_SLEEP 12'h014
`define OFS_KICK 12'h018

// control register fields
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 1
`define CTRL_WAIT_BIT 2
`define SRC_INT 2'h0
`define SRC_INT16 2'h1
`define SRC_INT256 2'h2
`define SRC_EXT 2'h3
`define CTRL_EDGE_BIT 3
`define CTRL_RESET 4'h0

// status register fields
`define ST_BUSY_BIT 0
`define ST_SLEEP_BIT 1
`define ST_WAIT_BIT 2
`define ST_WDT_BIT 3

// oscillator periods per counted tick
`define DIV_INT 4
`define DIV_INT16 64
`define DIV_INT256 1024

// timing
`define CLK_HZ 25000000
`define MS_NS 1000000
`define CLK_NS 40
`define CYC_PER_MS (`MS_NS / `CLK_NS)
`define SLEEP_MS 18
`define WDT_MS 18

`endif

// ===== design/edge_sync.v
// Purpose: three-stage synchroniser with edge detection for the counter pin
// Assumes: pin is asynchronous to sys_clk
// Notes: an edge counts once stages two and three agree on a new level
`timescale 1ns/100ps
module edge_sync (
  input wire sys_clk,
  input wire rst,
  input wire pinIn,
  output reg riseEvt,
  output reg fallEvt
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg level_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      riseEvt <= 1'b0;
      fallEvt <= 1'b0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      riseEvt <= 1'b0;
      fallEvt <= 1'b0;
      // one pulse per settled change so each edge counts once
      if (s2_r == s3_r && s3_r != level_r) begin
        level_r <= s3_r;
        riseEvt <= s3_r;
        fallEvt <= ~s3_r;
      end
    end
  end
endmodule

// ===== sim/edge_cycle_counter_checker.sv
// Purpose: port checks for the counter and sleep timer block
// Assumes: one clock, sync active-high rst
// Notes: idle count restarts on psel; the watchdog restarts on psel with penable or while busy
`timescale 1ns/100ps
module edge_cycle_counter_checker #(
  parameter WDT_CYCLES = 50
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleeping,
  input wire wdtReset
);
  int idleCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always @(posedge sys_clk)
    idleCnt <= (rst || psel) ? 0 : idleCnt + 1;
  AST_ACK_NEXT: assert property (
    $rose(penable) && psel && paddr == 12'h000 |=> pready)
    else $error("count access not answered in one cycle");
  AST_RD_HIGH: assert property (
    pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0)
    else $error("count read has upper bits set");
  AST_ACK_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_HOLE: assert property (
    pslverr |-> pready && !(paddr inside {12'h000, 12'h004, 12'h008,
    12'h00c, 12'h010, 12'h014, 12'h018}))
    else $error("slave error on a mapped place");
  AST_SLEEP_CAUSE: assert property (
    $rose(sleeping) |-> psel && pwrite && paddr == 12'h014)
    else $error("sleep began without a sleep write");
  AST_SLEEP_HOLD: assert property (sleeping |-> psel && penable)
    else $error("bus released during sleep");
  AST_WDT_EARLY: assert property (
    wdtReset |-> idleCnt >= WDT_CYCLES - 3)
    else $error("watchdog fired while restarted");
  AST_WDT_LATE: assert property (
    idleCnt == WDT_CYCLES - 4 |-> ##[1:8] wdtReset)
    else $error("watchdog missed its expiry");
  AST_WDT_PULSE: assert property (wdtReset |=> !wdtReset)
    else $error("watchdog pulse too long");
endmodule
bind edge_cycle_counter_sleep_timer edge_cycle_counter_checker #(
  .WDT_CYCLES(WDT_CYCLES)) u_chk (.sys_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .sleeping, .wdtReset);

// ===== sim/pulse_source.sv
// Purpose: external pulse source on the counter pin
// Assumes: half periods well above two clocks for the synchroniser
// Notes: pin rests low between bursts so it never floats
`timescale 1ns/100ps
module pulse_source (
  output logic pin
);
  initial pin = 1'h0;
  task automatic emit(input int n, input int halfNs);
    repeat (n) begin
      #(halfNs) pin = 1'h1;
      #(halfNs) pin = 1'h0;
    end
  endtask
endmodule

// ===== sim/tb_edge_cycle_counter_sleep_timer.sv
// Purpose: self-checking bench for the counter and sleep timer
// Assumes: shortened ms, sleep and watchdog counts
// Notes: ext source with a quiet pin freezes the count for exact checks
`timescale 1ns/100ps
`include "edge_cycle_counter_defs.vh"
module tb_edge_cycle_counter_sleep_timer;
  logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, countPin, sleeping, wdtReset, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int err_count, n_checks, cyc, wdts, w0, dv;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wdtReset === 1'h1) wdts++;
  edge_cycle_counter_sleep_timer #(.MS_CYCLES(10), .SLEEP_CYCLES(20),
    .WDT_CYCLES(50)) u_dut (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .countPin, .sleeping,
    .wdtReset);
  pulse_source u_src (.pin(countPin));
  task automatic chk(input logic [31:0] s, e, input string nm);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // waits on pready with no assumed latency; a hung wait ends the run
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    cyc = 0;
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (pready !== 1'h1 && cyc < 9000);
    if (pready !== 1'h1) begin
      err_count++;
      print_verdict;
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input string nm);
    apb(1'h0, a, 32'h0);
    chk(q, e, nm);
  endtask
  task automatic pulses(input int n, input int h);
    u_src.emit(n, h);
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    rd(`OFS_CTRL, 32'h0, "ctrl");
    rd(`OFS_STATUS, 32'h0, "status");
    rd(12'h01c, 32'h0, "hole");
    chk(err, 1'h1, "slverr");
    apb(1'h1, `OFS_CTRL, 32'h3);
    apb(1'h1, `OFS_COUNT, 32'hfd);
    rd(`OFS_COUNT, 32'hfd, "load");
    pulses(3, 130);
    rd(`OFS_COUNT, 32'h0, "wrap");
    pulses(2, 700);
    rd(`OFS_COUNT, 32'h2, "rise");
    apb(1'h1, `OFS_CTRL, 32'hb);
    pulses(5, 130);
    rd(`OFS_COUNT, 32'h7, "fall");
    $display("test edges finished");
    // prescaler runs free, so a window of one tick either way
    for (int s = 0; s < 3; s++) begin
      dv = s == 0 ? `DIV_INT : s == 1 ? `DIV_INT16 : `DIV_INT256;
      apb(1'h1, `OFS_CTRL, 32'(s));
      apb(1'h1, `OFS_COUNT, 32'h0);
      repeat (5 * dv - 3) @(posedge sys_clk);
      apb(1'h0, `OFS_COUNT, 32'h0);
      chk(q > 3 && q < 7, 1'h1, "rate");
    end
    $display("test rates finished");
    apb(1'h1, `OFS_CTRL, 32'h3);
    apb(1'h1, `OFS_COUNT, 32'h33);
    fork
      apb(1'h1, `OFS_GATE, 32'h14);
      #410 u_src.emit(7, 200);
    join
    chk(q, 32'h7, "gate");
    chk(cyc >= 200 && cyc <= 208, 1'h1, "gate time");
    rd(`OFS_GATE, 32'h7, "gate last");
    apb(1'h1, `OFS_DELAY, 32'h10003);
    chk(cyc >= 30 && cyc <= 38, 1'h1, "delay");
    apb(1'h1, `OFS_COUNT, 32'hfc);
    fork
      apb(1'h1, `OFS_CTRL, 32'h7);
      #410 u_src.emit(4, 200);
    join
    chk(cyc > 40, 1'h1, "wait time");
    rd(`OFS_COUNT, 32'h0, "wait end");
    rd(`OFS_CTRL, 32'h3, "wait bit");
    $display("test operations finished");
    apb(1'h1, `OFS_COUNT, 32'h10);
    fork
      apb(1'h1, `OFS_SLEEP, 32'h3);
      #410 u_src.emit(3, 200);
    join
    chk(cyc >= 60 && cyc <= 66, 1'h1, "sleep");
    apb(1'h0, `OFS_COUNT, 32'h0);
    chk(q >= 32'h10 && q <= 32'h13, 1'h1, "frozen");
    rd(`OFS_CTRL, 32'h0, "ctrl after sleep");
    $display("test sleep finished");
    w0 = wdts;
    repeat (40) @(posedge sys_clk);
    apb(1'h1, `OFS_KICK, 32'h0);
    repeat (40) @(posedge sys_clk);
    chk(wdts, w0, "kicked");
    repeat (20) @(posedge sys_clk);
    chk(wdts, w0 + 1, "expired");
    rd(`OFS_STATUS, 32'h8, "wdt flag");
    $display("test watchdog finished");
    print_verdict;
  end
endmodule
